//--- lsp_pkg.sv
// Shared constants and types for the LED driver serial port
package lsp_pkg;
    localparam int LSP_WORD_W = 16;
    localparam logic [4:0] LSP_LAST_BIT = 5'h10;
    localparam logic [15:0] LSP_START_WORD = 16'hFFFF;
    localparam logic [1:0] LSP_WORDS_PER_IRQ = 2'h3;
    localparam logic LSP_IDLE_LEVEL = 1'h1;
    localparam int LSP_TX_GAP_X2 = 18;

    typedef enum logic [1:0] {
        LSP_TX_IDLE = 2'b00,
        LSP_TX_START = 2'b01,
        LSP_TX_DATA = 2'b10
    } lsp_tx_state_t;

    typedef enum logic {
        LSP_RX_IDLE = 1'b0,
        LSP_RX_ACTIVE = 1'b1
    } lsp_rx_state_t;

    // Check bit is the complement of the last data bit of the word
    function automatic logic lsp_check_bit(input logic [15:0] word);
        lsp_check_bit = ~word[0];
    endfunction
endpackage

//--- lsp_sync.sv
// Two-flop synchroniser for levels entering a clock domain
`timescale 1ns/10ps
module lsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // First stage is read only by the second stage
    always_ff @(posedge clk) begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end
endmodule

//--- led_driver_serial_port.sv
// Framed serial port to a daisy-chained LED driver, both directions
//
// Functional notes
// - Start bit opens frame; capture word, verify check
// - Wrong check bit raises the mismatch flag
// - End-of-frame bits send receiver back to idle
// - End bits raise word-received and check error
// - Start marker is an all-ones word first
// - Start bit comes from check logic, cycle 17
// - Output held at one after the last word
// - Serializer bit registered before driving the pin
// - Each 16-bit word carries a verified check bit
// - Interrupt after every four received words
// - Shifting timed on double-rate clock falling edges
// - Receive disabled forces start detection inactive
`timescale 1ns/10ps
module led_driver_serial_port
    import lsp_pkg::*;
#(
    parameter int WORD_W = LSP_WORD_W
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [lsp_pkg::LSP_WORD_W-1:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic rx_enable,
    output logic [lsp_pkg::LSP_WORD_W-1:0] rx_data,
    output logic rx_valid,
    output logic check_mismatch_flag,
    output logic rx_frame_end,
    output logic rx_quad_irq,
    input wire logic double_rate_shift_clock,
    output logic forwarded_double_clock,
    output logic shift_clock_out,
    output logic serial_data_out,
    input wire logic serial_data_in
);
    import lsp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // System side: transmit holding word and handshake toggles
    logic [WORD_W-1:0] tx_hold_reg;
    logic tx_hold_last_reg;
    logic tx_full_reg;
    logic tx_put_tgl_reg;
    logic tx_ack_seen_reg;
    logic tx_ack_sync;

    // Holding word stays stable until the link acknowledges its copy
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_hold_reg <= '0;
            tx_hold_last_reg <= 1'b0;
            tx_put_tgl_reg <= 1'b0;
        end else if (tx_valid && tx_ready) begin
            tx_hold_reg <= tx_data;
            tx_hold_last_reg <= tx_last;
            tx_put_tgl_reg <= ~tx_put_tgl_reg;
        end
    end

    // Full is set on a put and cleared when the link acknowledges
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tx_full_reg <= 1'b0;
            tx_ack_seen_reg <= 1'b0;
        end else begin
            tx_ack_seen_reg <= tx_ack_sync;
            if (tx_valid && tx_ready) begin
                tx_full_reg <= 1'b1;
            end else if (tx_ack_sync != tx_ack_seen_reg) begin
                tx_full_reg <= 1'b0;
            end
        end
    end
    assign tx_ready = ~tx_full_reg;

    ////////////////////////////////////////////////////////////////////
    // Crossings into the link domain
    logic link_reset;
    logic tx_put_sync;
    logic rx_enable_sync;
    logic sin_sync;
    logic link_clk_n;

    assign link_clk_n = ~double_rate_shift_clock;

    // Link logic works on falling edges, so synchronisers use the inverse
    lsp_sync #(.WIDTH(4)) u_link_sync (
        .clk(link_clk_n),
        .async_in({reset, tx_put_tgl_reg, rx_enable, serial_data_in}),
        .sync_out({link_reset, tx_put_sync, rx_enable_sync, sin_sync})
    );

    ////////////////////////////////////////////////////////////////////
    // Link side transmitter
    lsp_tx_state_t tx_state_reg;
    logic [WORD_W-1:0] tx_shift_reg;
    logic tx_shift_last_reg;
    logic [4:0] tx_bit_reg;
    logic tx_put_seen_reg;
    logic tx_ack_tgl_reg;
    logic sout_reg;
    logic sclk_reg;
    logic tx_word_pending;
    logic tx_bit_next;

    assign tx_word_pending = (tx_put_sync != tx_put_seen_reg);

    // Bits 0..15 are data MSB first, bit 16 is the check bit
    always_comb begin
        if (tx_bit_reg == LSP_LAST_BIT) begin
            tx_bit_next = lsp_check_bit(tx_shift_reg);
        end else begin
            tx_bit_next = tx_shift_reg[WORD_W-1 - 32'(tx_bit_reg)];
        end
    end

    // Frame state machine: start word, data words, then idle high
    always_ff @(negedge double_rate_shift_clock) begin
        if (link_reset) begin
            tx_state_reg <= LSP_TX_IDLE;
            tx_shift_reg <= '0;
            tx_shift_last_reg <= 1'b0;
            tx_bit_reg <= '0;
            tx_put_seen_reg <= 1'b0;
            tx_ack_tgl_reg <= 1'b0;
        end else begin
            case (tx_state_reg)
                LSP_TX_IDLE: begin
                    tx_bit_reg <= '0;
                    if (tx_word_pending) begin
                        tx_state_reg <= LSP_TX_START;
                        tx_shift_reg <= LSP_START_WORD;
                    end
                end
                LSP_TX_START, LSP_TX_DATA: begin
                    if (tx_bit_reg != LSP_LAST_BIT) begin
                        tx_bit_reg <= tx_bit_reg + 5'h01;
                    end else if (tx_state_reg == LSP_TX_DATA
                                 && tx_shift_last_reg) begin
                        tx_state_reg <= LSP_TX_IDLE;
                    end else if (tx_word_pending) begin
                        // Word was stable for two edges before the copy
                        tx_state_reg <= LSP_TX_DATA;
                        tx_shift_reg <= tx_hold_reg;
                        tx_shift_last_reg <= tx_hold_last_reg;
                        tx_put_seen_reg <= tx_put_sync;
                        tx_ack_tgl_reg <= ~tx_ack_tgl_reg;
                        tx_bit_reg <= '0;
                    end else begin
                        // Underrun ends the frame rather than send junk
                        tx_state_reg <= LSP_TX_IDLE;
                    end
                end
                default: tx_state_reg <= LSP_TX_IDLE;
            endcase
        end
    end

    // Registered pin bit avoids glitches from serializer update delays
    always_ff @(negedge double_rate_shift_clock) begin
        if (link_reset) begin
            sout_reg <= LSP_IDLE_LEVEL;
        end else if (tx_state_reg == LSP_TX_IDLE) begin
            sout_reg <= LSP_IDLE_LEVEL;
        end else begin
            sout_reg <= tx_bit_next;
        end
    end
    assign serial_data_out = sout_reg;

    // Shift clock at half the double rate, runs only within a frame
    always_ff @(posedge double_rate_shift_clock) begin
        if (link_reset || tx_state_reg == LSP_TX_IDLE) begin
            sclk_reg <= 1'b0;
        end else begin
            sclk_reg <= ~sclk_reg;
        end
    end
    assign shift_clock_out = sclk_reg;
    assign forwarded_double_clock = double_rate_shift_clock;

    ////////////////////////////////////////////////////////////////////
    // Link side receiver
    lsp_rx_state_t rx_state_reg;
    logic [WORD_W-1:0] rx_shift_reg;
    logic [4:0] rx_bit_reg;
    logic [WORD_W-1:0] rx_word_reg;
    logic rx_err_reg;
    logic rx_end_reg;
    logic rx_tgl_reg;
    logic rx_start_seen;
    logic rx_check_bad;
    logic rx_end_seen;

    // A zero while idle and enabled opens a frame
    assign rx_start_seen = ~sin_sync & rx_enable_sync;
    assign rx_check_bad = (sin_sync != lsp_check_bit(rx_shift_reg));
    assign rx_end_seen = (rx_shift_reg == LSP_START_WORD) & sin_sync;

    // Capture 16 data bits and the check bit of each word
    always_ff @(negedge double_rate_shift_clock) begin
        if (link_reset) begin
            rx_state_reg <= LSP_RX_IDLE;
            rx_shift_reg <= '0;
            rx_bit_reg <= '0;
        end else begin
            case (rx_state_reg)
                LSP_RX_IDLE: begin
                    rx_bit_reg <= '0;
                    if (rx_start_seen) begin
                        rx_state_reg <= LSP_RX_ACTIVE;
                    end
                end
                LSP_RX_ACTIVE: begin
                    if (!rx_enable_sync) begin
                        rx_state_reg <= LSP_RX_IDLE;
                    end else if (rx_bit_reg != LSP_LAST_BIT) begin
                        rx_shift_reg <= {rx_shift_reg[WORD_W-2:0], sin_sync};
                        rx_bit_reg <= rx_bit_reg + 5'h01;
                    end else begin
                        rx_bit_reg <= '0;
                        if (rx_end_seen) begin
                            rx_state_reg <= LSP_RX_IDLE;
                        end
                    end
                end
                default: rx_state_reg <= LSP_RX_IDLE;
            endcase
        end
    end

    // Publish each word; it stays stable for 17 link cycles
    always_ff @(negedge double_rate_shift_clock) begin
        if (link_reset) begin
            rx_word_reg <= '0;
            rx_err_reg <= 1'b0;
            rx_end_reg <= 1'b0;
            rx_tgl_reg <= 1'b0;
        end else if (rx_state_reg == LSP_RX_ACTIVE && rx_enable_sync
                     && rx_bit_reg == LSP_LAST_BIT) begin
            rx_word_reg <= rx_shift_reg;
            rx_err_reg <= rx_check_bad;
            rx_end_reg <= rx_end_seen;
            rx_tgl_reg <= ~rx_tgl_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Crossings back into the system domain
    logic rx_tgl_sync;
    logic rx_tgl_seen_reg;
    logic [1:0] rx_count_reg;

    lsp_sync #(.WIDTH(2)) u_sys_sync (
        .clk(sys_clk),
        .async_in({tx_ack_tgl_reg, rx_tgl_reg}),
        .sync_out({tx_ack_sync, rx_tgl_sync})
    );

    // Word and flags are copied once the toggle has settled
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_tgl_seen_reg <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= '0;
            check_mismatch_flag <= 1'b0;
            rx_frame_end <= 1'b0;
        end else begin
            rx_tgl_seen_reg <= rx_tgl_sync;
            rx_valid <= (rx_tgl_sync != rx_tgl_seen_reg);
            if (rx_tgl_sync != rx_tgl_seen_reg) begin
                rx_data <= rx_word_reg;
                check_mismatch_flag <= rx_err_reg;
                rx_frame_end <= rx_end_reg;
            end
        end
    end

    // Every fourth word pulses the interrupt; a frame end restarts it
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_count_reg <= '0;
            rx_quad_irq <= 1'b0;
        end else begin
            rx_quad_irq <= 1'b0;
            if (rx_tgl_sync != rx_tgl_seen_reg) begin
                if (rx_end_reg) begin
                    rx_count_reg <= '0;
                end else begin
                    rx_count_reg <= rx_count_reg + 2'h1;
                    if (rx_count_reg == LSP_WORDS_PER_IRQ) begin
                        rx_quad_irq <= 1'b1;
                    end
                end
            end
        end
    end
endmodule

//--- lsp_port_properties.sv
// Concurrent checks on the serial port's receive flags and link pins
`timescale 1ns/10ps
module lsp_port_properties (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic rx_enable,
    input wire logic rx_valid,
    input wire logic check_mismatch_flag,
    input wire logic rx_frame_end,
    input wire logic rx_quad_irq,
    input wire logic double_rate_shift_clock,
    input wire logic shift_clock_out,
    input wire logic serial_data_out
);
    // The system clock is three times faster, so it sees every link edge
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////////
    property p_end_err;
        rx_valid && rx_frame_end |-> check_mismatch_flag;
    endproperty
    a_end_err: assert property (p_end_err) else $error("end ok");
    property p_pulse; rx_valid |=> (!rx_valid) [*8]; endproperty
    a_pulse: assert property (p_pulse) else $error("valid long");
    property p_quad; rx_quad_irq |-> rx_valid && !rx_frame_end; endproperty
    a_quad: assert property (p_quad) else $error("stray quad");
    property p_flag; $changed(check_mismatch_flag) |-> rx_valid; endproperty
    a_flag: assert property (p_flag) else $error("flag moved");
    logic [4:0] off_cnt_reg;
    // Cycles with reception off; long enough for an in-flight word to drain
    always_ff @(posedge sys_clk) begin
        if (reset || rx_enable) begin
            off_cnt_reg <= 5'h00;
        end else if (off_cnt_reg != 5'h1F) begin
            off_cnt_reg <= off_cnt_reg + 5'h01;
        end
    end
    property p_off; off_cnt_reg == 5'h1F |-> !rx_valid; endproperty
    a_off: assert property (p_off) else $error("rx while off");
    property p_sdo;
        $changed(serial_data_out) |-> !double_rate_shift_clock;
    endproperty
    a_sdo: assert property (p_sdo) else $error("sdo off fall");
    property p_sclk;
        $changed(shift_clock_out) |-> double_rate_shift_clock;
    endproperty
    a_sclk: assert property (p_sclk) else $error("sclk off rise");
    // A stopped shift clock means no frame, so the line must idle high
    property p_idle; (!shift_clock_out) [*8] |-> serial_data_out; endproperty
    a_idle: assert property (p_idle) else $error("idle low");
    ////////////////////////////////////////////////////////////////////////
    c_quad: cover property (rx_quad_irq);
    c_end: cover property (rx_valid && rx_frame_end);
    c_bad: cover property (rx_valid && check_mismatch_flag && !rx_frame_end);
endmodule
bind led_driver_serial_port lsp_port_properties u_props (.*);

//--- lsp_led_model.sv
// LED driver model: decodes the port's frames and sends frames back
`timescale 1ns/10ps
module lsp_led_model (
    input wire logic dclk,
    input wire logic sdo,
    output logic sdi
);
    logic [16:0] sr = 17'h00000;
    int ones = 0;
    int cnt = -1;
    logic [16:0] got_q[$];
    initial sdi = 1'h1;
    // Sample mid-bit on rises, since the port moves data on falls
    always @(posedge dclk) begin
        sr = {sr[15:0], sdo};
        if (cnt < 0) begin
            if (!sdo && ones >= 16) cnt = 0;
            ones = sdo ? ones + 1 : 0;
        end else begin
            cnt = cnt + 1;
            if (cnt == 17) begin
                cnt = 0;
                if (sr == 17'h1FFFF) cnt = -1;
                else got_q.push_back(sr);
            end
        end
    end
    // One bit per period, set well ahead of the sampling fall
    task automatic put_bits(input logic [16:0] b, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge dclk);
            sdi <= b[i];
        end
    endtask
endmodule

//--- test_led_driver_serial_port.sv
// Self-checking bench: host port, link clock and LED driver model
`timescale 1ns/10ps
module test_led_driver_serial_port;
    import lsp_pkg::*;
    logic sys_clk = 1'h0;
    logic dclk = 1'h0;
    logic reset = 1'h1;
    logic [15:0] tx_data = 16'h0000;
    logic tx_last = 1'h0;
    logic tx_valid = 1'h0;
    logic rx_enable = 1'h1;
    logic tx_ready, rx_valid, cmf, rx_frame_end, rx_quad_irq;
    logic [15:0] rx_data;
    logic fwd, sclk, sdo, sdi;
    logic [19:0] rec_q[$];
    int failures = 0;
    int samples_checked = 0;
    int sclk_rises = 0;
    led_driver_serial_port u_dut (.sys_clk(sys_clk), .reset(reset),
        .tx_data(tx_data), .tx_last(tx_last), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_enable(rx_enable), .rx_data(rx_data),
        .rx_valid(rx_valid), .check_mismatch_flag(cmf),
        .rx_frame_end(rx_frame_end), .rx_quad_irq(rx_quad_irq),
        .double_rate_shift_clock(dclk), .forwarded_double_clock(fwd),
        .shift_clock_out(sclk), .serial_data_out(sdo),
        .serial_data_in(sdi));
    lsp_led_model u_led (.dclk(fwd), .sdo(sdo), .sdi(sdi));
    // Odd offset keeps the two clocks' edges apart
    initial forever #2 sys_clk = ~sys_clk;
    initial begin
        #5;
        forever #6 dclk = ~dclk;
    end
    // Received words as {0, end, mismatch, quad, data}
    always @(negedge sys_clk) begin
        if (rx_valid === 1'h1) begin
            rec_q.push_back({1'h0, rx_frame_end, cmf, rx_quad_irq, rx_data});
        end
    end
    // Shift clock rises, to show it runs only for the frame's bits
    always @(posedge sclk) sclk_rises = sclk_rises + 1;
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic guard(inout int t);
        @(negedge sys_clk);
        t = t + 1;
        if (t > 3000) begin
            failures++;
            close_out();
        end
    endtask
    // Offer a word and hold it until ready is seen before the taking edge
    task automatic put(input logic [15:0] w, input logic last);
        int t = 0;
        @(negedge sys_clk);
        tx_data = w;
        tx_last = last;
        tx_valid = 1'h1;
        while (tx_ready !== 1'h1) guard(t);
        @(negedge sys_clk);
        tx_valid = 1'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // A cut frame offers no last word and must end on the underrun
    task automatic tx_frame(input logic [15:0] w[$], input logic cut);
        int t = 0;
        int n0 = sclk_rises;
        u_led.got_q.delete();
        foreach (w[i]) put(w[i], i == w.size() - 1 && !cut);
        while (u_led.got_q.size() < w.size()) guard(t);
        foreach (w[i]) begin
            cmp({3'h0, u_led.got_q[i]}, {3'h0, w[i], ~w[i][0]});
        end
        repeat (60) @(negedge sys_clk);
        cmp({19'h0, sdo}, 20'h00001);
        cmp(20'(u_led.got_q.size()), 20'(w.size()));
        cmp(20'(sclk_rises - n0), 20'(17 * (w.size() + 1) / 2));
        $display("tx frame of %0d words done", w.size());
    endtask
    task automatic rx_frame(input logic [15:0] w[$], input logic [7:0] bad);
        int t = 0;
        rec_q.delete();
        u_led.put_bits(17'h00000, 1);
        foreach (w[i]) u_led.put_bits({w[i], ~w[i][0] ^ bad[i]}, 17);
        u_led.put_bits(17'h1FFFF, 17);
        while (rec_q.size() < w.size() + 1) guard(t);
        foreach (w[i]) begin
            cmp(rec_q[i], {2'h0, bad[i], i % 4 == 3, w[i]});
        end
        cmp(rec_q[w.size()], 20'h6FFFF);
        rec_q.pop_back();
        $display("rx frame of %0d words done", w.size());
    endtask
    // A disabled receiver must ignore a whole frame
    task automatic rx_off;
        rec_q.delete();
        @(negedge sys_clk);
        rx_enable = 1'h0;
        repeat (20) @(negedge sys_clk);
        u_led.put_bits(17'h00000, 1);
        u_led.put_bits(17'h0AAAB, 17);
        u_led.put_bits(17'h1FFFF, 17);
        repeat (40) @(negedge sys_clk);
        cmp(20'(rec_q.size()), 20'h00000);
        rx_enable = 1'h1;
        repeat (20) @(negedge sys_clk);
        $display("rx disabled done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Reset spans four link periods so the link side is cleared too
    task automatic reset_state;
        repeat (12) @(negedge sys_clk);
        cmp({13'h0, tx_ready, sdo, sclk, rx_valid, cmf, rx_frame_end,
            rx_quad_irq}, 20'h00060);
        reset = 1'h0;
        repeat (20) @(negedge sys_clk);
        $display("reset state done");
    endtask
    initial begin
        reset_state();
        tx_frame('{16'h5555}, 1'h0);
        tx_frame('{16'hFFFF, 16'h0001, 16'h8000}, 1'h0);
        tx_frame('{16'h3C3C}, 1'h1);
        rx_frame('{16'hAAAA, 16'h0000, 16'hFFFF, 16'h1234, 16'h8001},
            8'h00);
        rx_frame('{16'h5555, 16'hC3C3, 16'h0F0F}, 8'h02);
        rx_off();
        close_out();
    end
endmodule
